// [src/ttc_pkg.sv]
// How it works
// R01: sample interval settable 0.2 ms to 1000 ms
// R02: 1024 sample buffer per channel
// R03: four channels, integer or real source
// R04: control bits 1-4 pick real format
// R05: trigger compares two integer or real operands
// R06: alternative trigger on one watched bit
// R07: pre-trigger count settable 0 to 1022
// R08: control bit 0 starts collection
// R09: status bit 1 flags triggered
// R10: status bit 2 flags complete
// R11: control bit 15 starts automatic replay
// R12: replay uses interval latched at replay start
// R13: integer start marker during replay
// R14: real start marker during replay
// R15: signed index selects displayed sample
// R16: replay steps index through full range
// R17: integer and real output word per channel
// R18: fill post-trigger part, then stop and flag
// R19: trigger looked at only after pre-fill
package ttc_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int UNIT_TIME_NS  = 100000;
   localparam int UNIT_CYCLES   = UNIT_TIME_NS / CLK_PERIOD_NS;
   localparam int RATE_MIN_NS   = 200000;
   localparam int RATE_MAX_NS   = 1000000000;
   localparam int NCH           = 4;
   localparam int DW            = 32;
   localparam int AW            = 10;
   localparam int DEPTH         = 1024;
   localparam int RW            = 14;
   localparam logic [RW-1:0] RATE_MIN = RW'(RATE_MIN_NS / UNIT_TIME_NS);
   localparam logic [RW-1:0] RATE_MAX = RW'(RATE_MAX_NS / UNIT_TIME_NS);
   localparam logic [RW-1:0] RATE_RST = 14'h000a;
   localparam logic [AW-1:0] PRE_MAX  = 10'h3fe;
   localparam logic [AW:0]   IDX_LAST = 11'h3ff;
   // register byte offsets
   localparam logic [5:0] A_CTRL  = 6'h00;
   localparam logic [5:0] A_STAT  = 6'h04;
   localparam logic [5:0] A_RATE  = 6'h08;
   localparam logic [5:0] A_PRE   = 6'h0c;
   localparam logic [5:0] A_TBIT  = 6'h10;
   localparam logic [5:0] A_INDEX = 6'h14;
   localparam logic [5:0] A_IRQST = 6'h18;
   localparam logic [5:0] A_IRQMK = 6'h1c;
   // control fields
   localparam int C_COLLECT  = 0;
   localparam int C_REAL_LSB = 1;
   localparam int C_TSEL_LSB = 5;
   localparam int C_AUTO     = 15;
   localparam logic [1:0] TSEL_INT  = 2'h0;
   localparam logic [1:0] TSEL_REAL = 2'h1;
   localparam logic [1:0] TSEL_BIT  = 2'h2;
   // status fields
   localparam int S_BUSY   = 0;
   localparam int S_TRIG   = 1;
   localparam int S_DONE   = 2;
   localparam int S_REPLAY = 3;
   localparam int I_TRIG   = 0;
   localparam int I_DONE   = 1;
   localparam logic [DW-1:0] MARK_INT_ON  = 32'h00000001;
   localparam logic [DW-1:0] MARK_REAL_ON = 32'h3f800000;

   typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_REPLAY} ttc_fsm_type;

   typedef struct packed {
      ttc_fsm_type             state;
      logic [15:0]             ctrl;
      logic [RW-1:0]           rate;
      logic [RW-1:0]           period;
      logic [AW-1:0]           pre;
      logic [4:0]              tbit;
      logic signed [AW:0]      index;
      logic [AW-1:0]           wr_ptr;
      logic [AW-1:0]           trig_ptr;
      logic [AW-1:0]           cnt;
      logic [11:0]             unit_cnt;
      logic [RW-1:0]           per_cnt;
      logic                    triggered;
      logic                    complete;
      logic [1:0]              irq_st;
      logic [1:0]              irq_mk;
      logic                    irq;
      logic [DW-1:0]           rdata;
      logic                    mark_d;
      logic [DW-1:0]           mark_int;
      logic [DW-1:0]           mark_real;
      logic [NCH-1:0][DW-1:0]  out_int;
      logic [NCH-1:0][DW-1:0]  out_real;
   } ttc_state_type;
endpackage : ttc_pkg

// [src/ttc_trace.sv]
module ttc_trace
   import ttc_pkg::*;
#(
   parameter int UNIT_CYC = UNIT_CYCLES
) (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   input  wire logic [5:0]             i_addr,
   input  wire logic [DW-1:0]          i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output      logic [DW-1:0]          o_rdata,
   output      logic                   o_irq,
   input  wire logic [NCH-1:0][DW-1:0] i_chan_input_int,
   input  wire logic [NCH-1:0][DW-1:0] i_chan_input_real,
   input  wire logic [DW-1:0]          i_trig_operand_a_int,
   input  wire logic [DW-1:0]          i_trig_operand_b_int,
   input  wire logic [DW-1:0]          i_trig_operand_a_real,
   input  wire logic [DW-1:0]          i_trig_operand_b_real,
   input  wire logic [DW-1:0]          i_trig_watch,
   output      logic [NCH-1:0][DW-1:0] o_chan_output_int,
   output      logic [NCH-1:0][DW-1:0] o_chan_output_real,
   output      logic [DW-1:0]          o_start_marker_int,
   output      logic [DW-1:0]          o_start_marker_real
);

   // ****************************************
   // helpers
   // ****************************************
   // map a float onto an unsigned key with the same ordering
   function automatic logic [DW-1:0] float_key(input logic [DW-1:0] f);
      float_key = f[DW-1] ? ~f : (f ^ 32'h80000000);
   endfunction : float_key

   function automatic logic signed [AW:0] first_index(input logic [AW-1:0] pre);
      first_index = -$signed({1'b0, pre});
   endfunction : first_index

   // ****************************************
   // storage
   // ****************************************
   ttc_state_type                 s_r;
   ttc_state_type                 s_nxt;
   logic [NCH*DW-1:0]             mem [DEPTH];
   logic [NCH-1:0][DW-1:0]        mem_q;
   logic                          mem_we;
   logic [NCH-1:0][DW-1:0]        mem_wd;
   logic [AW-1:0]                 rd_addr;
   logic                          unit_wrap;
   logic                          tick;
   logic                          hit;
   logic                          finish;
   logic [RW-1:0]                 wr_rate;
   logic [AW-1:0]                 wr_pre;

   assign rd_addr = s_r.trig_ptr + s_r.index[AW-1:0]; // R15

   always_ff @(posedge i_clock) begin
      if (mem_we) begin
         mem[s_r.wr_ptr] <= mem_wd; // R02
      end
      mem_q <= mem[rd_addr];
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt     = s_r;
      mem_we    = 1'b0;
      hit       = 1'b0;
      finish    = 1'b0;
      wr_rate   = i_wdata[RW-1:0];
      wr_pre    = i_wdata[AW-1:0];
      for (int i = 0; i < NCH; i++) begin
         mem_wd[i] = s_r.ctrl[C_REAL_LSB+i] ? i_chan_input_real[i] : i_chan_input_int[i]; // R03 R04
      end

      // sample interval divider
      unit_wrap = s_r.unit_cnt == 12'(UNIT_CYC - 1);
      tick      = unit_wrap && (s_r.per_cnt == s_r.period - 1'b1); // R01
      s_nxt.unit_cnt = unit_wrap ? 12'h000 : s_r.unit_cnt + 1'b1;
      if (unit_wrap) begin
         s_nxt.per_cnt = tick ? '0 : s_r.per_cnt + 1'b1;
      end

      case (s_r.ctrl[C_TSEL_LSB+:2])
         TSEL_INT:  hit = $signed(i_trig_operand_a_int) > $signed(i_trig_operand_b_int); // R05
         TSEL_REAL: hit = float_key(i_trig_operand_a_real) > float_key(i_trig_operand_b_real); // R05
         TSEL_BIT:  hit = i_trig_watch[s_r.tbit]; // R06
         default:   hit = 1'b0;
      endcase

      // bus writes
      if (i_wr) begin
         if (i_addr == A_CTRL) begin
            s_nxt.ctrl = i_wdata[15:0];
         end else if (i_addr == A_RATE) begin
            if (wr_rate < RATE_MIN) begin
               s_nxt.rate = RATE_MIN; // R01
            end else if (wr_rate > RATE_MAX) begin
               s_nxt.rate = RATE_MAX; // R01
            end else begin
               s_nxt.rate = wr_rate;
            end
         end else if (i_addr == A_PRE) begin
            s_nxt.pre = (wr_pre > PRE_MAX) ? PRE_MAX : wr_pre; // R07
         end else if (i_addr == A_TBIT) begin
            s_nxt.tbit = i_wdata[4:0];
         end else if (i_addr == A_INDEX) begin
            if (s_r.state == ST_IDLE) begin
               s_nxt.index = i_wdata[AW:0]; // R15
            end
         end else if (i_addr == A_IRQST) begin
            s_nxt.irq_st = s_r.irq_st & ~i_wdata[1:0];
         end else if (i_addr == A_IRQMK) begin
            s_nxt.irq_mk = i_wdata[1:0];
         end
      end

      case (s_r.state)
         ST_IDLE: begin
            if (s_r.ctrl[C_COLLECT]) begin
               s_nxt.state     = ST_PRE; // R08
               s_nxt.wr_ptr    = '0;
               s_nxt.cnt       = '0;
               s_nxt.triggered = 1'b0;
               s_nxt.complete  = 1'b0;
               s_nxt.period    = s_r.rate;
               s_nxt.unit_cnt  = '0;
               s_nxt.per_cnt   = '0;
            end else if (s_r.ctrl[C_AUTO] && s_r.complete) begin
               s_nxt.state    = ST_REPLAY; // R11
               s_nxt.index    = first_index(s_r.pre);
               s_nxt.period   = s_r.rate; // R12
               s_nxt.unit_cnt = '0;
               s_nxt.per_cnt  = '0;
            end
         end
         ST_PRE: begin
            if (!s_r.ctrl[C_COLLECT]) begin
               s_nxt.state = ST_IDLE;
            end else begin
               if (tick) begin
                  mem_we       = 1'b1;
                  s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
               end
               if (s_r.cnt >= s_r.pre) begin
                  s_nxt.state = ST_ARMED; // R19
               end else if (tick) begin
                  s_nxt.cnt = s_r.cnt + 1'b1;
               end
            end
         end
         ST_ARMED: begin
            if (!s_r.ctrl[C_COLLECT]) begin
               s_nxt.state = ST_IDLE;
            end else if (tick) begin
               mem_we       = 1'b1;
               s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
               if (hit) begin
                  s_nxt.trig_ptr  = s_r.wr_ptr;
                  s_nxt.triggered = 1'b1; // R09
                  s_nxt.irq_st[I_TRIG] = 1'b1;
                  s_nxt.cnt       = PRE_MAX + 1'b1 - s_r.pre;
                  s_nxt.state     = ST_POST;
                  finish          = (s_r.pre == PRE_MAX + 1'b1);
               end
            end
         end
         ST_POST: begin
            if (!s_r.ctrl[C_COLLECT]) begin
               s_nxt.state = ST_IDLE;
            end else if (tick) begin
               mem_we       = 1'b1; // R18
               s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
               s_nxt.cnt    = s_r.cnt - 1'b1;
               finish       = (s_r.cnt == 10'h001);
            end
         end
         ST_REPLAY: begin
            if (!s_r.ctrl[C_AUTO]) begin
               s_nxt.state = ST_IDLE;
            end else if (tick) begin
               if (s_r.index == $signed(IDX_LAST - {1'b0, s_r.pre})) begin
                  s_nxt.index = first_index(s_r.pre); // R16
               end else begin
                  s_nxt.index = s_r.index + 1'b1; // R16
               end
            end
         end
         default: s_nxt.state = ST_IDLE;
      endcase

      if (finish) begin
         s_nxt.complete          = 1'b1; // R10 R18
         s_nxt.irq_st[I_DONE]    = 1'b1;
         s_nxt.ctrl[C_COLLECT]   = 1'b0;
         s_nxt.state             = ST_IDLE;
      end

      // displayed samples, held while collecting
      if (s_r.state == ST_IDLE || s_r.state == ST_REPLAY) begin
         for (int i = 0; i < NCH; i++) begin
            s_nxt.out_int[i]  = s_r.ctrl[C_REAL_LSB+i] ? '0 : mem_q[i]; // R17
            s_nxt.out_real[i] = s_r.ctrl[C_REAL_LSB+i] ? mem_q[i] : '0; // R17
         end
      end

      // marker delayed to line up with the read pipeline
      s_nxt.mark_d    = (s_r.state == ST_REPLAY) && (s_r.index == first_index(s_r.pre));
      s_nxt.mark_int  = s_r.mark_d ? MARK_INT_ON : '0; // R13
      s_nxt.mark_real = s_r.mark_d ? MARK_REAL_ON : '0; // R14

      s_nxt.rdata = '0;
      if (i_rd) begin
         if (i_addr == A_CTRL) begin
            s_nxt.rdata = {16'h0000, s_r.ctrl};
         end else if (i_addr == A_STAT) begin
            s_nxt.rdata[S_BUSY]   = s_r.state inside {ST_PRE, ST_ARMED, ST_POST};
            s_nxt.rdata[S_TRIG]   = s_r.triggered;
            s_nxt.rdata[S_DONE]   = s_r.complete;
            s_nxt.rdata[S_REPLAY] = s_r.state == ST_REPLAY;
         end else if (i_addr == A_RATE) begin
            s_nxt.rdata[RW-1:0] = s_r.rate;
         end else if (i_addr == A_PRE) begin
            s_nxt.rdata[AW-1:0] = s_r.pre;
         end else if (i_addr == A_TBIT) begin
            s_nxt.rdata[4:0] = s_r.tbit;
         end else if (i_addr == A_INDEX) begin
            s_nxt.rdata = 32'($signed(s_r.index));
         end else if (i_addr == A_IRQST) begin
            s_nxt.rdata[1:0] = s_r.irq_st;
         end else if (i_addr == A_IRQMK) begin
            s_nxt.rdata[1:0] = s_r.irq_mk;
         end
      end

      s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mk);

      if (i_rst) begin
         s_nxt      = '0;
         s_nxt.rate = RATE_RST;
      end
   end

   always_ff @(posedge i_clock) begin
      s_r <= s_nxt;
   end

   assign o_rdata             = s_r.rdata;
   assign o_irq               = s_r.irq;
   assign o_chan_output_int   = s_r.out_int;
   assign o_chan_output_real  = s_r.out_real;
   assign o_start_marker_int  = s_r.mark_int;
   assign o_start_marker_real = s_r.mark_real;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   sequence armed_hit_s;
      s_r.state == ST_ARMED && s_r.ctrl[C_COLLECT] && tick && hit;
   endsequence

   sequence post_last_s;
      s_r.state == ST_POST && s_r.ctrl[C_COLLECT] && tick && s_r.cnt == 10'h001;
   endsequence

   a_rate_range: assert property (s_r.rate >= RATE_MIN && s_r.rate <= RATE_MAX) // R01
      else $error("rate out of range");
   a_write_tick: assert property (mem_we |-> tick && s_r.state inside {ST_PRE, ST_ARMED, ST_POST}) // R01
      else $error("sample written off tick");
   a_pre_clamp: assert property (s_r.pre <= PRE_MAX) // R07
      else $error("pre count above limit");
   a_collect_start: assert property (s_r.state == ST_IDLE && s_r.ctrl[C_COLLECT] |=> s_r.state == ST_PRE) // R08
      else $error("collection did not start");
   a_trig_flag: assert property (armed_hit_s |=> s_r.triggered && s_r.trig_ptr == $past(s_r.wr_ptr)) // R09
      else $error("trigger not flagged");
   a_trig_guard: assert property ($rose(s_r.triggered) |-> $past(s_r.state) == ST_ARMED) // R19
      else $error("trigger outside armed state");
   a_done_flag: assert property (post_last_s |=> s_r.complete && s_r.state == ST_IDLE && !s_r.ctrl[C_COLLECT]) // R10
      else $error("completion not flagged");
   a_replay_step: assert property (s_r.state == ST_REPLAY && s_r.ctrl[C_AUTO] && tick
      && s_r.index != first_index(s_r.pre) - 1'b1 + 11'sh400
      |=> s_r.index != $past(s_r.index)) // R16
      else $error("replay index did not move");
   a_marker_int: assert property (s_r.state == ST_REPLAY && s_r.index == first_index(s_r.pre)
      ##1 s_r.state == ST_REPLAY |=> o_start_marker_int == MARK_INT_ON) // R13
      else $error("integer marker missing");
   a_marker_real: assert property (o_start_marker_real != '0 |-> $past(s_r.state, 2) == ST_REPLAY) // R14
      else $error("real marker outside replay");
   a_replay_hold: assert property (s_r.state == ST_REPLAY && $past(s_r.state) == ST_REPLAY |-> s_r.period == $past(s_r.period)) // R12
      else $error("replay interval changed");

endmodule : ttc_trace

// [verification/ttc_tb.sv]
module tb
   import ttc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int UC    = 4;
   localparam int TK    = 2 * UC;
   localparam int PRE   = 4;
   localparam int LIMIT = 90000;
   logic                   i_clock = 1'b0;
   logic                   i_rst, i_wr, i_rd, o_irq;
   logic [5:0]             i_addr;
   logic [DW-1:0]          i_wdata, o_rdata, a_int, b_int, a_real, b_real, watch, mk_int, mk_real;
   logic [NCH-1:0][DW-1:0] in_int = '0;
   logic [NCH-1:0][DW-1:0] in_real = '0;
   logic [NCH-1:0][DW-1:0] out_int, out_real;
   logic [31:0]            cyc = '0;
   int                     err_total = 0;
   int                     num_checks = 0;

   ttc_trace #(.UNIT_CYC(UC)) u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_chan_input_int(in_int),
      .i_chan_input_real(in_real), .i_trig_operand_a_int(a_int), .i_trig_operand_b_int(b_int),
      .i_trig_operand_a_real(a_real), .i_trig_operand_b_real(b_real), .i_trig_watch(watch),
      .o_chan_output_int(out_int), .o_chan_output_real(out_real), .o_start_marker_int(mk_int),
      .o_start_marker_real(mk_real));

   // ***************************************
   // clock and source data
   // ***************************************
   initial begin
      forever #25 i_clock = ~i_clock;
   end

   // sources carry the cycle number, so stored samples reveal their tick
   always @(posedge i_clock) begin
      cyc <= cyc + 32'd1;
      for (int c = 0; c < NCH; c++) begin
         in_int[c]  <= cyc + 32'(c);
         in_real[c] <= cyc + 32'h00010000 + 32'(c);
      end
   end

   // ***************************************
   // tasks
   // ***************************************
   task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [5:0] a, input logic [DW-1:0] d);
      @(posedge i_clock);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [DW-1:0] d);
      @(posedge i_clock);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(negedge i_clock);
      d = o_rdata;
   endtask : rd

   task automatic rchk(input logic [5:0] a, input logic [DW-1:0] exp, input string nm);
      logic [DW-1:0] d;
      rd(a, d);
      chk(nm, d, exp);
   endtask : rchk

   task automatic wait_stat(input int bitn, input int lim);
      logic [DW-1:0] d;
      int            n;
      d = '0;
      n = 0;
      while (d[bitn] !== 1'b1 && n < lim) begin
         rd(A_STAT, d);
         n++;
      end
   endtask : wait_stat

   task automatic wait_mark(output logic [31:0] t);
      int n;
      n = 0;
      // let a standing marker drop first, so only a fresh start is timed
      while (mk_int === MARK_INT_ON && n < 13000) begin
         @(negedge i_clock);
         n++;
      end
      while (mk_int !== MARK_INT_ON && n < 26000) begin
         @(negedge i_clock);
         n++;
      end
      t = cyc;
   endtask : wait_mark

   task automatic tally_and_finish();
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (LIMIT) @(posedge i_clock);
      err_total++;
      tally_and_finish();
   end

   // ***************************************
   // main sequence
   // ***************************************
   initial begin
      logic [31:0] t_start, t_set, v0, base, t0, t1;
      int          idx, w;
      i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = '0; i_wdata = '0;
      a_int = '0; b_int = '0; a_real = '0; b_real = '0; watch = '0;
      repeat (8) @(posedge i_clock);
      i_rst <= 1'b0;
      rchk(A_RATE, 32'h0000000a, "rate reset");
      rchk(A_CTRL, 32'h00000000, "ctrl reset");
      rchk(A_STAT, 32'h00000000, "status reset");
      wr(6'h20, 32'hffffffff);
      rchk(6'h20, 32'h00000000, "unmapped read");
      wr(A_RATE, 32'h00000001);
      rchk(A_RATE, 32'h00000002, "rate low clamp");
      wr(A_RATE, 32'h00003fff);
      rchk(A_RATE, 32'h00002710, "rate high clamp");
      wr(A_PRE, 32'h000003ff);
      rchk(A_PRE, 32'h000003fe, "pretrigger clamp");
      wr(A_PRE, 32'(PRE));
      wr(A_RATE, 32'h00000002);
      wr(A_TBIT, 32'h00000007);
      wr(A_IRQMK, 32'h00000003);
      for (int m = 0; m < 3; m++) begin
         if (m == 0) begin
            @(posedge i_clock);
            a_int <= 32'h00000001;
            b_int <= 32'hffffffff;
         end
         wr(A_CTRL, 32'h00000015 | 32'(m << 5));
         t_start = cyc;
         t_set   = cyc;
         rchk(A_STAT, 32'h00000001, "status after start");
         if (m != 0) begin
            repeat (60) @(posedge i_clock);
            rchk(A_STAT, 32'h00000001, "status before hit");
            @(posedge i_clock);
            if (m == 1) begin
               a_real <= 32'h3f800000;
               b_real <= 32'hc0000000;
            end else begin
               watch <= 32'h00000080;
            end
            t_set = cyc;
         end
         wait_stat(S_TRIG, 40);
         rchk(A_IRQST, 32'h00000001, "irq trig status");
         wait_stat(S_DONE, 4200);
         rchk(A_STAT, 32'h00000006, "status complete");
         rchk(A_CTRL, 32'h00000014 | 32'(m << 5), "collect cleared");
         @(posedge i_clock);
         a_int <= '0; b_int <= '0; a_real <= '0; b_real <= '0; watch <= '0;
         wr(A_IRQMK, 32'h00000000);
         @(negedge i_clock);
         chk("irq masked", {31'h0, o_irq}, 32'h0);
         wr(A_IRQMK, 32'h00000003);
         @(negedge i_clock);
         chk("irq raised", {31'h0, o_irq}, 32'h1);
         wr(A_IRQST, 32'h00000003);
         @(negedge i_clock);
         chk("irq cleared", {31'h0, o_irq}, 32'h0);
         wr(A_INDEX, 32'hfffffffc);
         rchk(A_INDEX, 32'hfffffffc, "index readback");
         wr(A_INDEX, 32'h0);
         repeat (3) @(negedge i_clock);
         v0 = out_int[0];
         chk("hit window", 32'((v0 + 32'd2 - t_set) <= 32'((m == 0) ? TK * PRE + 2 * TK : 2 * TK)), 32'h1);
         chk("pre filled", 32'((v0 - t_start + 32'(TK)) >= 32'(TK * PRE)), 32'h1);
         for (int k = 0; k < 3; k++) begin
            idx = (k == 0) ? -PRE : ((k == 1) ? 1 : 1023 - PRE);
            wr(A_INDEX, 32'(idx));
            repeat (3) @(negedge i_clock);
            base = v0 + 32'(TK * idx);
            for (int c = 0; c < NCH; c++) begin
               chk("out int", out_int[c], (c % 2 == 1) ? '0 : base + 32'(c));
               chk("out real", out_real[c], (c % 2 == 1) ? base + 32'h00010000 + 32'(c) : '0);
            end
         end
      end
      wr(A_RATE, 32'h00000003);
      wr(A_CTRL, 32'h00008014);
      wr(A_RATE, 32'h00000002);
      rchk(A_STAT, 32'h0000000e, "replay status");
      wait_mark(t0);
      chk("marker real", mk_real, MARK_REAL_ON);
      chk("first replayed", out_int[0], v0 - 32'(TK * PRE));
      w = 0;
      while (mk_int === MARK_INT_ON && w < 100) begin
         @(negedge i_clock);
         w++;
      end
      chk("marker width", 32'(w), 32'(3 * UC));
      chk("second replayed", out_int[0], v0 - 32'(TK * PRE) + 32'(TK));
      wait_mark(t1);
      chk("replay period", t1 - t0, 32'(DEPTH * 3 * UC));
      wr(A_CTRL, 32'h00000014);
      rchk(A_STAT, 32'h00000006, "replay stopped");
      tally_and_finish();
   end
endmodule : tb
